// ---- core/jtd_pkg.sv ----
// Constants, opcodes and state type for the test access port decoder
// Functional notes
// - Port uses clock, mode select, data in and data out only; no reset pin
// - Sixteen-state controller steps on rising test clock using sampled mode select
// - Undriven mode select or data input is seen as logic one
// - Data input shifts into the register chosen by state and instruction
// - Data output changes on falling test clock, driven only while shifting
// - Output source is instruction register or instruction-selected data register
// - Instruction register is six bits, decoded as bits five down to zero
// - Instruction register holds opcode and captures device status bits
// - Extest, sample/preload and intest opcodes select the boundary register
// - Boundary register has input, output and enable bits per pin
// - Two user opcodes assert their chain select and route chain output out
// - Configuration load and readback opcodes select a 64-bit register
// - Identification and user code opcodes select 32-bit capture registers
// - Bypass opcode selects one-bit bypass; high-impedance opcode also floats pins
// - Start-up stepping only with test clock source; shutdown stepping always
// - Reprogram opcode acts like the program reset pin, clearing configuration
// - Port ignores mode pins and takes precedence whenever active
// - User chains usable only after configuration; all others always
// - Bypass register loads zero in Capture-DR
// - Update latches load in Update-DR while clock is low and hold
// - Identification value always has its lowest bit set
package jtd_pkg;
    // Sizes
    localparam int IR_W       = 6;
    localparam int DR_W       = 64;
    localparam int NUM_IO     = 4;
    localparam int BSR_STRIDE = 3;
    localparam int BSR_W      = BSR_STRIDE * NUM_IO;
    localparam int BSR_IN_OFS = 0;
    localparam int BSR_OUT_OFS = 1;
    localparam int BSR_OE_OFS = 2;
    localparam int SYNC_W     = 5 + NUM_IO;
    localparam logic [6:0] LEN_BYP = 7'h01;
    localparam logic [6:0] LEN_32  = 7'h20;
    localparam logic [6:0] LEN_CFG = 7'h40;
    localparam logic [6:0] LEN_BSR = 7'(BSR_W);
    localparam logic [6:0] LEN_ONE = 7'h01;
    localparam logic [2:0] TLR_COUNT = 3'h5;

    // Opcodes
    localparam logic [IR_W-1:0] OP_EXTEST   = 6'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE   = 6'h01;
    localparam logic [IR_W-1:0] OP_USER_CHAIN_ONE = 6'h02;
    localparam logic [IR_W-1:0] OP_USER_CHAIN_TWO = 6'h03;
    localparam logic [IR_W-1:0] OP_CFG_RD   = 6'h04;
    localparam logic [IR_W-1:0] OP_CFG_LD   = 6'h05;
    localparam logic [IR_W-1:0] OP_INTEST   = 6'h07;
    localparam logic [IR_W-1:0] OP_USERCODE = 6'h08;
    localparam logic [IR_W-1:0] OP_IDCODE   = 6'h09;
    localparam logic [IR_W-1:0] OP_HIGHZ    = 6'h0a;
    localparam logic [IR_W-1:0] OP_REPROG   = 6'h0b;
    localparam logic [IR_W-1:0] OP_STARTUP  = 6'h0c;
    localparam logic [IR_W-1:0] OP_SHUTDOWN = 6'h0d;
    localparam logic [IR_W-1:0] OP_BYPASS   = 6'h3f;

    // Instruction capture: fixed 01 in the low bits plus status
    localparam logic [IR_W-1:0] IR_CAP_BASE = 6'h01;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_SRC_BIT  = 3;

    // Identification value, arbitrary neutral code
    localparam logic [31:0] ID_VALUE = 32'h0abc_d001;

    // Register map
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_USERCODE = 8'h04;
    localparam logic [7:0] ADR_STATUS   = 8'h08;
    localparam int CTRL_SRC_BIT   = 0;
    localparam int CTRL_DONE_BIT  = 1;
    localparam int STAT_IR_LSB    = 4;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] USERCODE_RST = 32'hffff_ffff;

    // Controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } jtd_state_t;
endpackage

// ---- core/jtd_tap.sv ----
// Test access port controller, instruction decoder and data registers
`timescale 1ns/100ps
module jtd_tap (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // Test port pins
    input  wire logic                       tck_i,
    input  wire logic                       tms_i,
    input  wire logic                       tms_drv_i,
    input  wire logic                       tdi_i,
    input  wire logic                       tdi_drv_i,
    output logic                            tdo_o,
    output logic                            tdo_oe_o,
    // Boundary pins and core side
    input  wire logic [jtd_pkg::NUM_IO-1:0] pin_in_i,
    input  wire logic [jtd_pkg::NUM_IO-1:0] core_out_i,
    input  wire logic [jtd_pkg::NUM_IO-1:0] core_oe_i,
    output logic      [jtd_pkg::NUM_IO-1:0] pin_out_o,
    output logic      [jtd_pkg::NUM_IO-1:0] pin_oe_o,
    output logic      [jtd_pkg::NUM_IO-1:0] core_in_o,
    // User chains
    input  wire logic                       user_tdo1_i,
    input  wire logic                       user_tdo2_i,
    output logic                            user_sel1_o,
    output logic                            user_sel2_o,
    output logic                            user_tdi_o,
    output logic                            user_capture_o,
    output logic                            user_shift_o,
    output logic                            user_update_o,
    output logic                            user_reset_o,
    // Configuration engine
    input  wire logic [jtd_pkg::DR_W-1:0]   readback_word_i,
    output logic      [jtd_pkg::DR_W-1:0]   cfg_word_o,
    output logic                            cfg_word_stb_o,
    output logic                            startup_step_o,
    output logic                            shutdown_step_o,
    output logic                            cfg_clear_o
);
    import jtd_pkg::*;

    // Standard sixteen-state graph
    function automatic jtd_state_t jtd_next(input jtd_state_t st, input logic tms);
        case (st)
            TLR:     jtd_next = tms ? TLR    : RTI;
            RTI:     jtd_next = tms ? SEL_DR : RTI;
            SEL_DR:  jtd_next = tms ? SEL_IR : CAP_DR;
            CAP_DR:  jtd_next = tms ? EX1_DR : SH_DR;
            SH_DR:   jtd_next = tms ? EX1_DR : SH_DR;
            EX1_DR:  jtd_next = tms ? UPD_DR : PA_DR;
            PA_DR:   jtd_next = tms ? EX2_DR : PA_DR;
            EX2_DR:  jtd_next = tms ? UPD_DR : SH_DR;
            UPD_DR:  jtd_next = tms ? SEL_DR : RTI;
            SEL_IR:  jtd_next = tms ? TLR    : CAP_IR;
            CAP_IR:  jtd_next = tms ? EX1_IR : SH_IR;
            SH_IR:   jtd_next = tms ? EX1_IR : SH_IR;
            EX1_IR:  jtd_next = tms ? UPD_IR : PA_IR;
            PA_IR:   jtd_next = tms ? EX2_IR : PA_IR;
            EX2_IR:  jtd_next = tms ? UPD_IR : SH_IR;
            UPD_IR:  jtd_next = tms ? SEL_DR : RTI;
            default: jtd_next = TLR;
        endcase
    endfunction

    // Shift right, inserting the new bit at the chain's top
    function automatic logic [DR_W-1:0] dr_shift(input logic [DR_W-1:0] v, input logic b, input logic [6:0] len);
        logic [DR_W-1:0] r;
        r = v >> 1;
        r[6'(len - LEN_ONE)] = b;
        return r;
    endfunction

    // Interleave pin input, output and enable into boundary cells
    function automatic logic [BSR_W-1:0] bsr_pack(input logic [NUM_IO-1:0] i, input logic [NUM_IO-1:0] o,
                                                  input logic [NUM_IO-1:0] e);
        logic [BSR_W-1:0] r;
        r = '0;
        for (int k = 0; k < NUM_IO; k++) begin
            r[BSR_STRIDE*k+BSR_IN_OFS]  = i[k];
            r[BSR_STRIDE*k+BSR_OUT_OFS] = o[k];
            r[BSR_STRIDE*k+BSR_OE_OFS]  = e[k];
        end
        return r;
    endfunction

    // Pull one field per pin out of the boundary cells
    function automatic logic [NUM_IO-1:0] bsr_field(input logic [BSR_W-1:0] v, input int ofs);
        logic [NUM_IO-1:0] r;
        r = '0;
        for (int k = 0; k < NUM_IO; k++) begin
            r[k] = v[BSR_STRIDE*k+ofs];
        end
        return r;
    endfunction

    // Byte-lane write merge
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (sel[k]) begin
                r[8*k +: 8] = d[8*k +: 8];
            end
        end
        return r;
    endfunction

    logic [SYNC_W-1:0]  sync1_ff;
    logic [SYNC_W-1:0]  sync2_ff;
    logic               tck_d_ff;
    jtd_state_t         state_ff;
    logic [IR_W-1:0]    ir_ff;
    logic [IR_W-1:0]    ir_sh_ff;
    logic [DR_W-1:0]    dr_ff;
    logic [BSR_W-1:0]   bsr_upd_ff;
    logic [31:0]        ctrl_ff;
    logic [31:0]        usercode_ff;
    logic [2:0]         tms_hi_cnt_ff;

    // Pin inputs through two flops; only the second stage is read
    always_ff @(posedge clk_i) begin
        sync1_ff <= {tck_i, tms_i, tms_drv_i, tdi_i, tdi_drv_i, pin_in_i};
        sync2_ff <= sync1_ff;
        tck_d_ff <= sync2_ff[SYNC_W-1];
    end

    // Decoded pins; an undriven input reads as high like the pull-up
    wire               tck_s    = sync2_ff[SYNC_W-1];
    wire               tms_eff  = sync2_ff[SYNC_W-3] ? sync2_ff[SYNC_W-2] : 1'b1;
    wire               tdi_eff  = sync2_ff[SYNC_W-5] ? sync2_ff[SYNC_W-4] : 1'b1;
    wire [NUM_IO-1:0]  pin_s    = sync2_ff[NUM_IO-1:0];
    wire               tck_rise = tck_s & ~tck_d_ff;
    wire               tck_fall = ~tck_s & tck_d_ff;
    wire               done     = ctrl_ff[CTRL_DONE_BIT];
    wire               src_tck  = ctrl_ff[CTRL_SRC_BIT];

    // Instruction decode; user chains exist only once configured
    wire sel_bsr  = (ir_ff == OP_EXTEST) | (ir_ff == OP_SAMPLE) | (ir_ff == OP_INTEST);
    wire sel_usr1 = (ir_ff == OP_USER_CHAIN_ONE) & done;
    wire sel_usr2 = (ir_ff == OP_USER_CHAIN_TWO) & done;
    wire sel_usr  = sel_usr1 | sel_usr2;
    wire sel_cfg  = (ir_ff == OP_CFG_LD) | (ir_ff == OP_CFG_RD);
    wire sel_id   = (ir_ff == OP_IDCODE);
    wire sel_uc   = (ir_ff == OP_USERCODE);
    // Anything else, reserved codes included, falls to bypass
    wire sel_byp  = ~(sel_bsr | sel_usr | sel_cfg | sel_id | sel_uc);
    wire drive_bs = (ir_ff == OP_EXTEST) | (ir_ff == OP_INTEST);

    // Chain length and capture value of the selected data register
    wire [6:0]       dr_len  = sel_bsr ? LEN_BSR : sel_cfg ? LEN_CFG : (sel_id | sel_uc) ? LEN_32 : LEN_BYP;
    wire [BSR_W-1:0] bsr_cap = bsr_pack(pin_s, core_out_i, core_oe_i);
    wire [DR_W-1:0]  dr_cap  = sel_bsr ? DR_W'(bsr_cap) :
                               (ir_ff == OP_CFG_RD) ? readback_word_i :
                               sel_id ? DR_W'(ID_VALUE | 32'h0000_0001) :
                               sel_uc ? DR_W'(usercode_ff) :
                               '0;
    wire [IR_W-1:0]  ir_cap  = IR_CAP_BASE | (IR_W'(done) << ST_DONE_BIT) | (IR_W'(src_tck) << ST_SRC_BIT);

    // Serial source: instruction path or the chosen data path
    wire dr_bit  = sel_usr1 ? user_tdo1_i : sel_usr2 ? user_tdo2_i : dr_ff[0];
    wire ser_bit = (state_ff == SH_IR) ? ir_sh_ff[0] : dr_bit;
    wire shifting = (state_ff == SH_IR) | (state_ff == SH_DR);

    // Controller steps on each rising test clock; no mode pins are consulted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= TLR;
        end else if (tck_rise) begin
            state_ff <= jtd_next(state_ff, tms_eff);
        end
    end

    // Count of consecutive high mode selects, for the reset check
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tms_hi_cnt_ff <= '0;
        end else if (tck_rise) begin
            tms_hi_cnt_ff <= !tms_eff ? 3'h0 : (tms_hi_cnt_ff == TLR_COUNT) ? TLR_COUNT : tms_hi_cnt_ff + 3'h1;
        end
    end

    // Instruction shift register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir_sh_ff <= IR_CAP_BASE;
        end else if (tck_rise && state_ff == CAP_IR) begin
            ir_sh_ff <= ir_cap;
        end else if (tck_rise && state_ff == SH_IR) begin
            ir_sh_ff <= {tdi_eff, ir_sh_ff[IR_W-1:1]};
        end
    end

    // Active opcode; reset state forces identification
    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff == TLR) begin
            ir_ff <= OP_IDCODE;
        end else if (tck_fall && state_ff == UPD_IR) begin
            ir_ff <= ir_sh_ff;
        end
    end

    // Shared data shift register, length set by the instruction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dr_ff <= '0;
        end else if (tck_rise && state_ff == CAP_DR) begin
            dr_ff <= dr_cap;
        end else if (tck_rise && state_ff == SH_DR) begin
            dr_ff <= dr_shift(dr_ff, tdi_eff, dr_len);
        end
    end

    // Update latches open in Update-DR after the clock falls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bsr_upd_ff <= '0;
        end else if (tck_fall && state_ff == UPD_DR && sel_bsr) begin
            bsr_upd_ff <= dr_ff[BSR_W-1:0];
        end
    end

    // Configuration word handed over at update; a one-cycle strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_word_o     <= '0;
            cfg_word_stb_o <= 1'b0;
        end else begin
            cfg_word_stb_o <= tck_fall && state_ff == UPD_DR && ir_ff == OP_CFG_LD;
            if (tck_fall && state_ff == UPD_DR && ir_ff == OP_CFG_LD) begin
                cfg_word_o <= dr_ff;
            end
        end
    end

    // Serial output moves only on the falling clock, floated off shift
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdo_o    <= 1'b1;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o    <= ser_bit;
            tdo_oe_o <= shifting;
        end
    end

    // Pin drive; high-impedance opcode floats every output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o <= '0;
            pin_oe_o  <= '0;
            core_in_o <= '0;
        end else begin
            pin_out_o <= drive_bs ? bsr_field(bsr_upd_ff, BSR_OUT_OFS) : core_out_i;
            pin_oe_o  <= (ir_ff == OP_HIGHZ) ? '0 : drive_bs ? bsr_field(bsr_upd_ff, BSR_OE_OFS) : core_oe_i;
            core_in_o <= (ir_ff == OP_INTEST) ? bsr_field(bsr_upd_ff, BSR_IN_OFS) : pin_s;
        end
    end

    // User chain strobes, one clk_i cycle per test clock edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            user_sel1_o    <= 1'b0;
            user_sel2_o    <= 1'b0;
            user_tdi_o     <= 1'b1;
            user_capture_o <= 1'b0;
            user_shift_o   <= 1'b0;
            user_update_o  <= 1'b0;
            user_reset_o   <= 1'b1;
        end else begin
            user_sel1_o    <= sel_usr1;
            user_sel2_o    <= sel_usr2;
            user_tdi_o     <= tdi_eff;
            user_capture_o <= tck_rise && state_ff == CAP_DR && sel_usr;
            user_shift_o   <= tck_rise && state_ff == SH_DR && sel_usr;
            user_update_o  <= tck_fall && state_ff == UPD_DR && sel_usr;
            user_reset_o   <= state_ff == TLR;
        end
    end

    // Sequencer steps in Run-Test-Idle; start-up needs the test clock source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            startup_step_o  <= 1'b0;
            shutdown_step_o <= 1'b0;
            cfg_clear_o     <= 1'b0;
        end else begin
            startup_step_o  <= tck_rise && state_ff == RTI && ir_ff == OP_STARTUP && src_tck;
            shutdown_step_o <= tck_rise && state_ff == RTI && ir_ff == OP_SHUTDOWN;
            cfg_clear_o     <= ir_ff == OP_REPROG;
        end
    end

    // Wishbone decode; unmapped reads give zero, writes are dropped
    wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        hit_ctrl = (wb_adr_i == ADR_CTRL);
    wire        hit_uc   = (wb_adr_i == ADR_USERCODE);
    wire        hit_stat = (wb_adr_i == ADR_STATUS);
    wire [31:0] stat_val = 32'({ir_ff, 4'(state_ff)});
    wire [31:0] rd_val   = hit_ctrl ? ctrl_ff : hit_uc ? usercode_ff : hit_stat ? stat_val : 32'h0000_0000;

    // Answer one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_val : '0;
        end
    end

    // Software registers; reserved control bits stay zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff     <= CTRL_RST;
            usercode_ff <= USERCODE_RST;
        end else if (wb_req && wb_we_i) begin
            if (hit_ctrl) begin
                ctrl_ff <= wb_merge(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_0003;
            end else if (hit_uc) begin
                usercode_ff <= wb_merge(usercode_ff, wb_dat_i, wb_sel_i);
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    tdo_only_fall_a:   assert property (!tck_fall |=> $stable(tdo_o) && $stable(tdo_oe_o))
        else $error("serial output moved off a falling edge");
    tdo_oe_shift_a:    assert property (tck_fall |=> tdo_oe_o == $past(shifting))
        else $error("serial output enable wrong for state");
    five_tms_tlr_a:    assert property (tms_hi_cnt_ff == TLR_COUNT |-> state_ff == TLR)
        else $error("five high mode selects did not reach reset");
    tlr_loads_id_a:    assert property (state_ff == TLR |=> ir_ff == OP_IDCODE)
        else $error("reset state did not load identification");
    bypass_zero_a:     assert property (tck_rise && state_ff == CAP_DR && sel_byp |=> dr_ff[0] == 1'b0)
        else $error("bypass not zero after capture");
    id_lsb_one_a:      assert property (tck_rise && state_ff == CAP_DR && sel_id |=> dr_ff[0] && dr_ff[31:1] == ID_VALUE[31:1])
        else $error("identification capture wrong");
    ir_capture_a:      assert property (tck_rise && state_ff == CAP_IR |=> ir_sh_ff[1:0] == IR_CAP_BASE[1:0])
        else $error("instruction capture pattern wrong");
    highz_float_a:     assert property (ir_ff == OP_HIGHZ |=> pin_oe_o == '0)
        else $error("pins driven under high-impedance opcode");
    user_after_cfg_a:  assert property (user_sel1_o || user_sel2_o |-> $past(done))
        else $error("user chain selected before configuration");
    startup_src_a:     assert property (startup_step_o |-> $past(src_tck) && $past(ir_ff == OP_STARTUP))
        else $error("start-up step without test clock source");
    wb_ack_pulse_a:    assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer held two cycles");

    shift_ir_c:  cover property (state_ff == UPD_IR ##1 ir_ff == OP_BYPASS);
    cfg_load_c:  cover property (cfg_word_stb_o);
    user_sh_c:   cover property (user_shift_o && user_sel1_o);
    extest_c:    cover property (ir_ff == OP_EXTEST && tdo_oe_o);
endmodule

// ---- dv/jtd_host.sv ----
// Behavioural scan host for the test port pins
`timescale 1ns/100ps
module jtd_host (
    // Pins toward the device
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    // Host drive state and serial return
    input  wire logic tdi_drv_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i
);
    // Clock stands low between frames
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h0;
    end
    // One 125 ns period; return sampled just before the rise
    task automatic step(input logic m, input logic v, output logic o);
        tms_o = m;
        tdi_o = tdi_drv_i ? v : ~tdi_o; // Released line never keeps its value
        #62.5 o = tdo_oe_i ? tdo_i : 1'h1; // Open-drain return is pulled up
        tck_o = 1'h1;
        #62.5 tck_o = 1'h0;
    endtask
    // Five high mode selects, then idle
    task automatic reset_tap();
        logic o;
        repeat (5) step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
    endtask
    // Capture, shift n bits LSB first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        step(1'h1, 1'h0, o);
        if (ir) step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
        step(1'h0, 1'h0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
    endtask
endmodule

// ---- dv/jtd_tap_tb.sv ----
// Self-checking bench for the scan port decoder
`timescale 1ns/100ps
module jtd_tap_tb;
    import jtd_pkg::*;
    logic        clk_i, sel1, sel2, tck, tms, tdi, tdo, tdo_oe, ack;
    logic        rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, tdi_drv = 1'h1, u1 = 1'h1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0]  pio = 4'h5, poe;
    logic [63:0] rb = 64'h0123_4567_89ab_cdef, d;
    int          n_mismatch, total_checks;
    jtd_tap jtd_tap_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tck_i(tck),
        .tms_i(tms), .tms_drv_i(1'h1), .tdi_i(tdi), .tdi_drv_i(tdi_drv), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .pin_in_i(pio), .core_out_i(pio), .core_oe_i(pio), .pin_out_o(), .pin_oe_o(poe), .core_in_o(),
        .user_tdo1_i(u1), .user_tdo2_i(~u1), .user_sel1_o(sel1), .user_sel2_o(sel2), .user_tdi_o(),
        .user_capture_o(), .user_shift_o(), .user_update_o(), .user_reset_o(), .readback_word_i(rb),
        .cfg_word_o(), .cfg_word_stb_o(), .startup_step_o(), .shutdown_step_o(), .cfg_clear_o());
    jtd_host jtd_host_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdi_drv_i(tdi_drv), .tdo_i(tdo),
        .tdo_oe_i(tdo_oe));
    // Compare and count
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    // Classic single bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= v;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        chk("ack", 64'h1, {63'h0, ack});
    endtask
    task automatic ld(input logic [5:0] op);
        jtd_host_inst.scan(1'h1, 6, {58'h0, op}, d);
    endtask
    task automatic scen_id();
        jtd_host_inst.reset_tap();
        jtd_host_inst.scan(1'h0, 32, 64'h0, d);
        chk("idcode", {32'h0, ID_VALUE}, d);
        chk("id_lsb", 64'h1, {63'h0, d[0]});
        chk("tdo_idle", 64'h0, {63'h0, tdo_oe});
    endtask
    // Capture status, then one-bit delay path with zero captured first
    task automatic scen_byp(input logic [5:0] op);
        jtd_host_inst.scan(1'h1, 6, {58'h0, op}, d);
        chk("ir_capture", {58'h0, IR_CAP_BASE}, d);
        jtd_host_inst.scan(1'h0, 8, 64'hb5, d);
        chk("bypass", 64'h6a, d);
        chk("sel1_off", 64'h0, {63'h0, sel1});
        chk("pin_oe", (op == OP_HIGHZ) ? 64'h0 : {60'h0, pio}, {60'h0, poe});
    endtask
    // Undriven data input reads high, so all ones load bypass
    task automatic scen_float();
        @(posedge clk_i);
        tdi_drv <= 1'h0;
        ld(6'h2a);
        jtd_host_inst.scan(1'h0, 8, 64'h0, d);
        chk("float_tdi", 64'hfe, d);
        @(posedge clk_i);
        tdi_drv <= 1'h1;
    endtask
    task automatic scen_regs();
        ld(OP_CFG_RD);
        jtd_host_inst.scan(1'h0, 64, 64'h0, d);
        chk("readback", rb, d);
        wb(1'h0, ADR_USERCODE, 32'h0);
        chk("uc_reset", {32'h0, USERCODE_RST}, {32'h0, q});
        wb(1'h0, 8'h0c, 32'h0);
        chk("unmapped", 64'h0, {32'h0, q});
        wb(1'h1, ADR_USERCODE, 32'h1234_5678);
        ld(OP_USERCODE);
        jtd_host_inst.scan(1'h0, 32, 64'h0, d);
        chk("usercode", 64'h1234_5678, d);
        wb(1'h1, ADR_CTRL, 32'h2);
        ld(OP_USER_CHAIN_ONE);
        chk("sel1_on", 64'h1, {63'h0, sel1});
        jtd_host_inst.scan(1'h0, 4, 64'h0, d);
        chk("user_tdo", 64'hf, d);
        wb(1'h0, ADR_STATUS, 32'h0);
        chk("opcode", {58'h0, OP_USER_CHAIN_ONE}, {58'h0, q[9:4]});
        ld(OP_USER_CHAIN_TWO);
        chk("sel2_on", 64'h1, {63'h0, sel2});
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    // Whole run needs well under 100 us
    initial begin
        #200us;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        scen_id();
        scen_byp(OP_BYPASS);
        scen_byp(OP_HIGHZ);
        scen_byp(6'h2a);
        scen_byp(OP_USER_CHAIN_ONE);
        scen_float();
        scen_regs();
        tally_and_finish();
    end
endmodule
